// ===== pkg/watchdog_defs.svh
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// Watchdog mode field encodings
`define WD_MODE_OFF        2'b00
`define WD_MODE_SOFT       2'b01
`define WD_MODE_AWAKE      2'b10
`define WD_MODE_ALWAYS     2'b11

// Time base: oscillator rate and base interval
`define WD_OSC_KHZ         31
`define WD_BASE_MS         1
`define WD_TICK_DIV        (`WD_OSC_KHZ * `WD_BASE_MS)
`define WD_TICK_W          5
`define WD_TICK_LAST       (5'(`WD_TICK_DIV - 1))

// Millisecond chain and period select
`define WD_MS_W            19
`define WD_PS_W            5
`define WD_PS_MAX          5'h12
`define WD_PS_RESET        5'h0B
`define WD_MS_ONE          19'h00001

// Register byte offsets
`define WD_ADDR_W          8
`define WD_OFS_CTRL        8'h00
`define WD_OFS_FLAGS       8'h04
`define WD_OFS_INTCTL      8'h08
`define WD_OFS_EVT_STAT    8'h0C
`define WD_OFS_EVT_CLR     8'h10
`define WD_OFS_EVT_EN      8'h14

// Field positions
`define WD_CTRL_SWEN_BIT   0
`define WD_CTRL_PS_LSB     1
`define WD_CTRL_PS_MSB     5
`define WD_FLAG_EXPIRY_BIT 4
`define WD_FLAG_SLEEP_BIT  3
`define WD_INT_GLOB_EN_BIT 7

// Event bits
`define WD_EVT_W           3
`define WD_EVT_RESET       0
`define WD_EVT_WAKE_TO     1
`define WD_EVT_WAKE_IRQ    2
`define WD_EVT_NONE        3'h0

`endif

// ===== pkg/watchdog_pkg.sv
`include "watchdog_defs.svh"

package watchdog_pkg;

  // Power state of the device
  typedef enum logic [0:0] {
    PWR_AWAKE  = 1'b0,
    PWR_ASLEEP = 1'b1
  } pwr_state_t;

  // Instruction and fault events from the core, one-cycle pulses
  typedef struct packed {
    logic clear_instr;
    logic sleep_instr;
    logic osc_fail;
  } core_evt_t;

  // Active-low status markers
  typedef struct packed {
    logic timer_expiry_marker_n;
    logic sleep_marker_n;
  } status_flags_t;

  // Software control of the watchdog
  typedef struct packed {
    logic [`WD_PS_W-1:0] timeout_period_sel;
    logic                soft_watchdog_enable;
  } wd_ctrl_t;

endpackage : watchdog_pkg

// ===== verilog/wd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with agreement filter for a pin input
module wd_pin_sync (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic stage1_reg;  // Metastability catcher, read only by stage2
  logic stage2_reg;  // Second stage
  logic stage3_reg;  // Third stage

  // Shift chain
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else if (clk_en) begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Output follows only once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      level_out <= 1'b0;
    end else if (clk_en && (stage2_reg == stage3_reg)) begin
      level_out <= stage3_reg;
    end
  end

endmodule : wd_pin_sync

`default_nettype wire

// ===== verilog/watchdog_sleep_wake.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Awake timeout without clear resets the device
// - Time base from slow oscillator, 1 ms
// - Mode 00 keeps watchdog always off
// - Mode 11 runs always, even asleep
// - Mode 10 runs awake, stops asleep
// - Mode 01 follows software enable bit
// - Period select sets 1 ms to 262144 ms
// - Period select resets to two seconds
// - Clears on reset, clear, sleep, wake, fail, disable
// - Oscillator divider change leaves count alone
// - Sleep entry clears, then keeps counting if enabled
// - Timeout asleep wakes device, updates both flags
// - Pending interrupt turns sleep into no-op
// - Interrupt during sleep wakes, clears, sets flags

`include "watchdog_defs.svh"

module watchdog_sleep_wake
  import watchdog_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`WD_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire logic                   low_freq_osc,
  input  wire logic [1:0]             watchdog_mode_sel,
  input  wire core_evt_t              core_evt,
  input  wire logic                   irq_pending,
  output var  logic                   device_reset_req,
  output var  logic                   wake_pulse,
  output var  logic                   asleep,
  output var  logic                   irq
);

  wd_ctrl_t                ctrl_reg;       // Software control word
  status_flags_t           flags_reg;      // Expiry and sleep markers
  logic                    global_irq_enable_reg;  // Global interrupt enable
  logic [`WD_EVT_W-1:0]    evt_stat_reg;   // Sticky event bits
  logic [`WD_EVT_W-1:0]    evt_en_reg;     // Event enables
  logic [`WD_EVT_W-1:0]    evt_set;        // Events this cycle
  pwr_state_t              pwr_reg;        // Awake or asleep
  logic [`WD_TICK_W-1:0]   tick_cnt_reg;   // Oscillator edges in this ms
  logic [`WD_MS_W-1:0]     ms_cnt_reg;     // Elapsed ms ticks
  logic [`WD_MS_W-1:0]     ms_limit;       // Last count before expiry
  logic [`WD_PS_W-1:0]     ps_eff;         // Period select, clamped
  logic                    osc_level;      // Filtered oscillator level
  logic                    osc_prev_reg;   // Previous filtered level
  logic                    osc_rise;       // Rising oscillator edge
  logic                    ms_tick;        // End of one base interval
  logic                    run;            // Watchdog is counting
  logic                    expire;         // Count reached the period
  logic                    sleep_enter;    // Sleep really executes
  logic                    wake_irq;       // Wake by interrupt
  logic                    wd_clear;       // Any clearing condition
  logic                    setup_ph;       // APB setup cycle
  logic                    wr_en;          // APB write access
  logic                    addr_hit;       // Decoded offset exists
  logic                    bad_addr_reg;   // Latched decode miss
  logic [31:0]             rd_mux;         // Read value of the address

  // Oscillator pin enters through the synchroniser
  wd_pin_sync u_osc_sync (
    .core_clk  (core_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .pin_in    (low_freq_osc),
    .level_out (osc_level)
  );

  // Edge detector on the filtered oscillator level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_prev_reg <= 1'b0;
    end else if (clk_en) begin
      osc_prev_reg <= osc_level;
    end
  end

  assign osc_rise = osc_level & ~osc_prev_reg;
  assign asleep   = (pwr_reg == PWR_ASLEEP);

  // Enable by mode, sleep state and software bit
  always_comb begin
    case (watchdog_mode_sel)
      `WD_MODE_ALWAYS: run = 1'b1;
      `WD_MODE_AWAKE:  run = ~asleep;
      `WD_MODE_SOFT:   run = ctrl_reg.soft_watchdog_enable;
      `WD_MODE_OFF:    run = 1'b0;
      default:         run = 1'b0;
    endcase
  end

  // Period select beyond the longest period clamps to it
  assign ps_eff   = (ctrl_reg.timeout_period_sel > `WD_PS_MAX) ? `WD_PS_MAX : ctrl_reg.timeout_period_sel;
  // Period is two to the power of the select, in ms
  assign ms_limit = (`WD_MS_ONE << ps_eff) - `WD_MS_ONE;

  // One base interval is a fixed count of oscillator edges
  assign ms_tick = run & osc_rise & (tick_cnt_reg == `WD_TICK_LAST);
  assign expire  = ms_tick & (ms_cnt_reg == ms_limit);

  // Sleep executes only with no interrupt already pending
  assign sleep_enter = ~asleep & core_evt.sleep_instr & ~irq_pending;
  assign wake_irq    = asleep & irq_pending & ~expire;

  // Every condition that restarts the count; divider changes are not one
  assign wd_clear = ~run | core_evt.clear_instr | core_evt.osc_fail |
                    sleep_enter | wake_irq | expire;

  // Prescaler and ms counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_reg <= '0;
      ms_cnt_reg   <= '0;
    end else if (clk_en) begin
      if (wd_clear) begin
        tick_cnt_reg <= '0;
        ms_cnt_reg   <= '0;
      end else if (ms_tick) begin
        tick_cnt_reg <= '0;
        ms_cnt_reg   <= ms_cnt_reg + `WD_MS_ONE;
      end else if (osc_rise) begin
        tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
    end
  end

  // Power state: sleep entry, then wake on timeout or interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_reg <= PWR_AWAKE;
    end else if (clk_en) begin
      case (pwr_reg)
        PWR_AWAKE: begin
          if (sleep_enter) begin
            pwr_reg <= PWR_ASLEEP;
          end
        end
        PWR_ASLEEP: begin
          if (expire || irq_pending) begin
            pwr_reg <= PWR_AWAKE;
          end
        end
        default: pwr_reg <= PWR_AWAKE;
      endcase
    end
  end

  // Reset request and wake pulse, one cycle each
  always_ff @(posedge core_clk) begin
    if (srst) begin
      device_reset_req <= 1'b0;
      wake_pulse       <= 1'b0;
    end else if (clk_en) begin
      device_reset_req <= expire & ~asleep;
      wake_pulse       <= asleep & (expire | irq_pending);
    end else begin
      device_reset_req <= 1'b0;
      wake_pulse       <= 1'b0;
    end
  end

  // Status markers, active low; timeout takes priority
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_reg <= '{timer_expiry_marker_n: 1'b1, sleep_marker_n: 1'b1};
    end else if (clk_en) begin
      if (expire && asleep) begin
        flags_reg.timer_expiry_marker_n <= 1'b0;
        flags_reg.sleep_marker_n        <= 1'b0;
      end else if (expire) begin
        flags_reg.timer_expiry_marker_n <= 1'b0;
      end else if (wake_irq) begin
        flags_reg.timer_expiry_marker_n <= 1'b1;
        flags_reg.sleep_marker_n        <= 1'b0;
      end else if (sleep_enter) begin
        flags_reg.timer_expiry_marker_n <= 1'b1;
        flags_reg.sleep_marker_n        <= 1'b0;
      end else if (core_evt.clear_instr) begin
        flags_reg.timer_expiry_marker_n <= 1'b1;
        flags_reg.sleep_marker_n        <= 1'b1;
      end
    end
  end

  // APB phase decode; the slave never inserts wait states
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & bad_addr_reg;

  // Offset decode
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `WD_OFS_CTRL: begin
        rd_mux[`WD_CTRL_PS_MSB:`WD_CTRL_PS_LSB] = ctrl_reg.timeout_period_sel;
        rd_mux[`WD_CTRL_SWEN_BIT]               = ctrl_reg.soft_watchdog_enable;
      end
      `WD_OFS_FLAGS: begin
        rd_mux[`WD_FLAG_EXPIRY_BIT] = flags_reg.timer_expiry_marker_n;
        rd_mux[`WD_FLAG_SLEEP_BIT]  = flags_reg.sleep_marker_n;
      end
      `WD_OFS_INTCTL:   rd_mux[`WD_INT_GLOB_EN_BIT] = global_irq_enable_reg;
      `WD_OFS_EVT_STAT: rd_mux[`WD_EVT_W-1:0]     = evt_stat_reg;
      `WD_OFS_EVT_CLR:  rd_mux                    = 32'h0000_0000;
      `WD_OFS_EVT_EN:   rd_mux[`WD_EVT_W-1:0]     = evt_en_reg;
      default:          addr_hit                  = 1'b0;
    endcase
  end

  // Read data and decode result are captured in the setup cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata       <= 32'h0000_0000;
      bad_addr_reg <= 1'b0;
    end else if (clk_en && setup_ph) begin
      prdata       <= pwrite ? 32'h0000_0000 : rd_mux;
      bad_addr_reg <= ~addr_hit;
    end
  end

  // Control register writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= '{timeout_period_sel: `WD_PS_RESET, soft_watchdog_enable: 1'b0};
      global_irq_enable_reg <= 1'b0;
    end else if (clk_en && wr_en) begin
      if (paddr == `WD_OFS_CTRL) begin
        ctrl_reg.timeout_period_sel   <= pwdata[`WD_CTRL_PS_MSB:`WD_CTRL_PS_LSB];
        ctrl_reg.soft_watchdog_enable <= pwdata[`WD_CTRL_SWEN_BIT];
      end
      if (paddr == `WD_OFS_INTCTL) begin
        global_irq_enable_reg <= pwdata[`WD_INT_GLOB_EN_BIT];
      end
    end
  end

  // Event sources
  assign evt_set[`WD_EVT_RESET]    = expire & ~asleep;
  assign evt_set[`WD_EVT_WAKE_TO]  = expire & asleep;
  assign evt_set[`WD_EVT_WAKE_IRQ] = wake_irq;

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evt_stat_reg <= `WD_EVT_NONE;
    end else if (clk_en) begin
      if (wr_en && (paddr == `WD_OFS_EVT_CLR)) begin
        evt_stat_reg <= (evt_stat_reg & ~pwdata[`WD_EVT_W-1:0]) | evt_set;
      end else begin
        evt_stat_reg <= evt_stat_reg | evt_set;
      end
    end
  end

  // Event enable register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evt_en_reg <= `WD_EVT_NONE;
    end else if (clk_en && wr_en && (paddr == `WD_OFS_EVT_EN)) begin
      evt_en_reg <= pwdata[`WD_EVT_W-1:0];
    end
  end

  // Level interrupt while any enabled event is pending
  assign irq = |(evt_stat_reg & evt_en_reg);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_mode_off_idle: assert property (
    (watchdog_mode_sel == `WD_MODE_OFF) |-> (!run && !expire))
    else $error("watchdog runs in off mode");

  chk_mode_always_run: assert property (
    (watchdog_mode_sel == `WD_MODE_ALWAYS) |-> run)
    else $error("watchdog stopped in always-on mode");

  chk_mode_awake_sleep: assert property (
    (watchdog_mode_sel == `WD_MODE_AWAKE) |-> (run == !asleep))
    else $error("awake-only mode runs while asleep");

  chk_mode_soft_en: assert property (
    (watchdog_mode_sel == `WD_MODE_SOFT) |-> (run == ctrl_reg.soft_watchdog_enable))
    else $error("software mode ignores enable bit");

  chk_awake_timeout_reset: assert property (
    (clk_en && expire && !asleep) |=> (device_reset_req && !flags_reg.timer_expiry_marker_n && ms_cnt_reg == '0))
    else $error("awake timeout gave no reset");

  chk_sleep_timeout_wake: assert property (
    (clk_en && expire && asleep) |=> (!device_reset_req && wake_pulse && !asleep &&
      !flags_reg.timer_expiry_marker_n && !flags_reg.sleep_marker_n))
    else $error("sleep timeout handled wrongly");

  chk_sleep_as_nop: assert property (
    (clk_en && !asleep && core_evt.sleep_instr && irq_pending && !global_irq_enable_reg && !expire &&
      !core_evt.clear_instr && !core_evt.osc_fail && run && !osc_rise)
      |=> (!asleep && flags_reg.sleep_marker_n == $past(flags_reg.sleep_marker_n) && ms_cnt_reg == $past(ms_cnt_reg)))
    else $error("sleep with pending interrupt was not a no-op");

  chk_irq_wake_flags: assert property (
    (clk_en && asleep && irq_pending && !expire) |=> (!asleep && wake_pulse && ms_cnt_reg == '0 &&
      tick_cnt_reg == '0 && flags_reg.timer_expiry_marker_n && !flags_reg.sleep_marker_n))
    else $error("interrupt wake handled wrongly");

  chk_clear_instr_zero: assert property (
    (clk_en && core_evt.clear_instr) |=> (ms_cnt_reg == '0 && tick_cnt_reg == '0))
    else $error("clear instruction left count");

  chk_reset_period: assert property (
    $past(srst) |-> (ctrl_reg.timeout_period_sel == `WD_PS_RESET))
    else $error("period select not two seconds after reset");

  // Each counted rise steps the prescaler; the last one of an interval wraps it
  chk_tick_step: assert property (
    (clk_en && osc_rise && !wd_clear) |=>
      (tick_cnt_reg == (($past(tick_cnt_reg) == `WD_TICK_LAST) ? 5'h00 : ($past(tick_cnt_reg) + 5'h01))))
    else $error("base interval count stepped wrongly");

  // A low clock enable holds every count and silences the pulse outputs
  chk_freeze_hold: assert property (
    !clk_en |=> ($stable(ms_cnt_reg) && $stable(tick_cnt_reg) && $stable(pwr_reg) &&
      !device_reset_req && !wake_pulse))
    else $error("state moved while clock enable was low");

endmodule : watchdog_sleep_wake

`default_nettype wire

// ===== dv/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Processor core on the far side: issues clear, sleep and fault events
module core_model
  import watchdog_pkg::*;
(
  input  wire logic      core_clk,
  output var  core_evt_t core_evt,
  output var  logic      irq_pending
);
  // Idle core: nothing issued, no interrupt flag set
  initial begin
    core_evt    = '0;
    irq_pending = 1'b0;
  end

  // One instruction event, a single-cycle pulse after a rising edge
  task automatic issue(input core_evt_t ev);
    @(posedge core_clk);
    core_evt <= ev;
    @(posedge core_clk);
    core_evt <= '0;
  endtask : issue

  // Level of the enabled interrupt flag, seen before or after a sleep
  task automatic set_irq(input logic v);
    @(posedge core_clk);
    irq_pending <= v;
  endtask : set_irq
endmodule : core_model

`default_nettype wire

// ===== dv/tb_watchdog_sleep_wake.sv
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.svh"

module tb_watchdog_sleep_wake
  import watchdog_pkg::*;
;
  localparam int CYC_MS = 248;  // Clocks per 1 ms: 31 oscillator rises, one each 8 clocks

  logic        core_clk          = 1'b0;
  logic        srst              = 1'b1;
  logic        clk_en            = 1'b1;  // Clock enable, dropped once to freeze the block
  logic        psel              = 1'b0;
  logic        penable           = 1'b0;
  logic        pwrite            = 1'b0;
  logic [7:0]  paddr             = 8'h00;
  logic [31:0] pwdata            = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        low_freq_osc      = 1'b0;  // Sped-up slow oscillator
  logic [1:0]  osc_div           = 2'h0;
  logic [1:0]  watchdog_mode_sel = `WD_MODE_ALWAYS;
  core_evt_t   core_evt;
  logic        irq_pending;
  logic        device_reset_req;
  logic        wake_pulse;
  logic        asleep;
  logic        irq;
  logic [31:0] q;                         // Last read data
  logic        e;                         // Last slave error
  logic [15:0] lfsr              = 16'hB634;
  int          m_exp;                     // Model: timeout marker
  int          m_slp;                     // Model: sleep marker
  int          w_base;                    // Wake count before a wake
  int          m_stat;                    // Model: event status
  int          rst_cnt           = 0;
  int          wake_cnt          = 0;
  int          fail_count        = 0;
  int          compares          = 0;

  // Clock and oscillator, one rise every 8 clocks
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) low_freq_osc <= ~low_freq_osc;
  end
  // Count every reset request and wake pulse
  always @(posedge core_clk) begin
    if (device_reset_req === 1'b1) rst_cnt++;
    if (wake_pulse === 1'b1) wake_cnt++;
  end

  watchdog_sleep_wake u_dut (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_freq_osc(low_freq_osc), .watchdog_mode_sel(watchdog_mode_sel),
    .core_evt(core_evt), .irq_pending(irq_pending), .device_reset_req(device_reset_req),
    .wake_pulse(wake_pulse), .asleep(asleep), .irq(irq)
  );
  core_model u_core (.core_clk(core_clk), .core_evt(core_evt), .irq_pending(irq_pending));

  // Next random value
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  // Expected flags word from the model
  function automatic logic [31:0] flags_exp();
    return (32'(m_exp) << `WD_FLAG_EXPIRY_BIT) | (32'(m_slp) << `WD_FLAG_SLEEP_BIT);
  endfunction : flags_exp

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read and compare data and error
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), q, exp);
    chk("slave error", {31'h0, e}, {31'h0, experr});
  endtask : rd

  // Program period and enable with random unused bits, then read back
  task automatic setc(input logic [4:0] sel, input logic swen);
    lfsr = step(lfsr);
    apb(1'b1, `WD_OFS_CTRL, {lfsr, lfsr[9:0], sel, swen});
    rd(`WD_OFS_CTRL, {26'h0, sel, swen}, 1'b0);
  endtask : setc

  // Reset with a chosen mode
  task automatic do_reset(input logic [1:0] mode);
    @(posedge core_clk);
    srst              <= 1'b1;
    watchdog_mode_sel <= mode;
    repeat (10) @(posedge core_clk);
    srst   <= 1'b0;
    m_exp  = 1;
    m_slp  = 1;
    m_stat = 0;
  endtask : do_reset

  // Expect a timeout about per clocks from now, then update the model
  task automatic expect_to(input logic wake, input int per);
    int cyc;
    cyc = 0;
    do begin
      @(posedge core_clk);
      cyc++;
    end while ((wake ? wake_pulse : device_reset_req) !== 1'b1 && cyc < per + 200);
    chk("timeout cycle", 32'(cyc >= per - 16 && cyc <= per + 24), 32'h1);
    m_exp = 0;
    if (wake) begin
      m_slp  = 0;
      m_stat = m_stat | 2;
    end else begin
      m_stat = m_stat | 1;
    end
  endtask : expect_to

  // No reset request and no wake for n clocks
  task automatic quiet(input int n);
    int r0;
    int w0;
    #1;
    r0 = rst_cnt;
    w0 = wake_cnt;
    repeat (n) @(posedge core_clk);
    #1;
    chk("reset count", rst_cnt, r0);
    chk("wake count", wake_cnt, w0);
  endtask : quiet

  // Interrupt output level after the last write landed
  task automatic irq_is(input logic v);
    #1;
    chk("irq", {31'h0, irq}, {31'h0, v});
  endtask : irq_is

  // Verdict and end of run
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    do_reset(`WD_MODE_ALWAYS);
    rd(`WD_OFS_CTRL, {26'h0, `WD_PS_RESET, 1'b0}, 1'b0);
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    apb(1'b1, `WD_OFS_INTCTL, 32'hFFFFFFFF);
    rd(`WD_OFS_INTCTL, 32'h80, 1'b0);
    apb(1'b1, `WD_OFS_EVT_EN, 32'h7);
    // Awake timeouts over several periods, soft enable ignored in mode 11
    for (int s = 0; s < 3; s++) begin
      setc(5'(s), 1'b0);
      u_core.issue(core_evt_t'(3'h4));
      expect_to(1'b0, CYC_MS << s);
    end
    rd(`WD_OFS_EVT_STAT, 32'(m_stat), 1'b0);
    irq_is(1'b1);
    apb(1'b1, `WD_OFS_EVT_EN, 32'h0);
    irq_is(1'b0);
    apb(1'b1, `WD_OFS_EVT_EN, 32'h7);
    apb(1'b1, `WD_OFS_EVT_CLR, 32'h1);
    m_stat = 0;
    irq_is(1'b0);
    rd(`WD_OFS_EVT_STAT, 32'h0, 1'b0);
    // Clears and oscillator faults at random gaps hold off the reset
    setc(5'h00, 1'b0);
    u_core.issue(core_evt_t'(3'h4));
    m_exp = 1;
    m_slp = 1;
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      repeat (100 + lfsr[6:0]) @(posedge core_clk);
      u_core.issue(core_evt_t'(i[0] ? 3'h1 : 3'h4));
    end
    quiet(100);
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    // Sleep in mode 11: cleared on entry, timeout wakes instead of reset
    u_core.issue(core_evt_t'(3'h2));
    m_slp = 0;
    #1 chk("asleep", {31'h0, asleep}, 32'h1);
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    quiet(CYC_MS - 40);
    expect_to(1'b1, 40);
    #1 chk("asleep", {31'h0, asleep}, 32'h0);
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    rd(`WD_OFS_EVT_STAT, 32'(m_stat), 1'b0);
    // Mode 10: stopped asleep, interrupt wakes at once
    do_reset(`WD_MODE_AWAKE);
    setc(5'h00, 1'b0);
    u_core.issue(core_evt_t'(3'h2));
    quiet(3 * CYC_MS);
    w_base = wake_cnt;
    u_core.set_irq(1'b1);
    quiet(0);
    repeat (3) @(posedge core_clk);
    chk("irq wakes", wake_cnt, w_base + 1);
    u_core.set_irq(1'b0);
    m_exp  = 1;
    m_slp  = 0;
    m_stat = 4;
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    rd(`WD_OFS_EVT_STAT, 32'(m_stat), 1'b0);
    expect_to(1'b0, CYC_MS - 10);
    // Mode 00 never runs; mode 01 follows the soft enable, asleep too
    do_reset(`WD_MODE_OFF);
    setc(5'h00, 1'b1);
    quiet(3 * CYC_MS);
    do_reset(`WD_MODE_SOFT);
    setc(5'h00, 1'b0);
    quiet(3 * CYC_MS);
    setc(5'h00, 1'b1);
    // Clock enable low for 100 clocks pushes the timeout back by as much
    clk_en <= 1'b0;
    repeat (100) @(posedge core_clk);
    clk_en <= 1'b1;
    expect_to(1'b0, CYC_MS - 4);
    u_core.issue(core_evt_t'(3'h2));
    expect_to(1'b1, CYC_MS);
    // Pending interrupt turns sleep into a no-op, count keeps running
    do_reset(`WD_MODE_ALWAYS);
    setc(5'h00, 1'b0);
    u_core.issue(core_evt_t'(3'h4));
    repeat (150) @(posedge core_clk);
    u_core.set_irq(1'b1);
    u_core.issue(core_evt_t'(3'h2));
    #1 chk("asleep", {31'h0, asleep}, 32'h0);
    rd(`WD_OFS_FLAGS, flags_exp(), 1'b0);
    expect_to(1'b0, CYC_MS - 157);
    u_core.set_irq(1'b0);
    end_of_test();
  end

  // Cut a hang short
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    $display("[FAIL] run length expected under 40000 cycles seen longer");
    end_of_test();
  end
endmodule : tb_watchdog_sleep_wake

`default_nettype wire
